// >>> wctc_pkg.sv
// Package for the selective wake trim and recovery configuration bank.
// Assumes one word-wide register port with 7-bit word addresses.
package wctc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;

    // Word addresses of the four registers
    localparam logic [6:0] OFS_TRIM_OPTIONS = 7'h3C;
    localparam logic [6:0] OFS_CAL_STATUS = 7'h3D;
    localparam logic [6:0] OFS_RECOVERY_CTRL = 7'h3E;
    localparam logic [6:0] OFS_BIT_TIME_LIMITS = 7'h3F;

    // Value of the trim unlock field that opens the protected fields
    localparam logic [1:0] TRIM_UNLOCK_KEY = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Field positions, trim and options register
    localparam int RXSEL_BIT = 14;
    localparam int TCOEF_HI = 11;
    localparam int TCOEF_LO = 7;
    localparam int COARSE_HI = 6;
    localparam int COARSE_LO = 0;

    // Field positions, recovery control register
    localparam int CLKSEL_HI = 6;
    localparam int CLKSEL_LO = 5;
    localparam int FILT_HI = 3;
    localparam int FILT_LO = 2;
    localparam int RECEN_BIT = 0;

    // Field positions, bit time limit register
    localparam int LIM_UP_HI = 15;
    localparam int LIM_UP_LO = 8;
    localparam int LIM_LO_HI = 7;
    localparam int LIM_LO_LO = 0;

    // Implemented bits; everything else is reserved and reads zero
    localparam logic [15:0] TRIM_IMPL_MASK = 16'h4FFF;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'h006D;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Reset values after power-on or soft reset
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam logic [15:0] CAL_RST = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0004;
    localparam logic [15:0] LIMIT_RST = 16'h9D8F;
    localparam logic [3:0] SPACING_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Edge filter modes and time constants
    typedef enum logic [1:0] {
        WCTC_FILT_TC8 = 2'h0,
        WCTC_FILT_TC16 = 2'h1,
        WCTC_FILT_TC32 = 2'h2,
        WCTC_FILT_ADAPT = 2'h3
    } wctc_filt_t;

    localparam logic [5:0] TC_8 = 6'h08;
    localparam logic [5:0] TC_16 = 6'h10;
    localparam logic [5:0] TC_32 = 6'h20;

    // Falling edge spacing bands in bit times for adaptive operation
    localparam logic [3:0] SP32_MIN = 4'h2;
    localparam logic [3:0] SP32_MAX = 4'h3;
    localparam logic [3:0] SP16_MIN = 4'h4;
    localparam logic [3:0] SP16_MAX = 4'h8;
    localparam logic [3:0] SP8_MIN = 4'h9;
    localparam logic [3:0] SP8_MAX = 4'hA;

    ////////////////////////////////////////////////////////////////////////
    // Recovery clock: base rate in kHz, halved per select step
    localparam logic [16:0] RCLK_BASE_KHZ = 17'h124F8;

    // Limit clamp: plus five and minus five percent of the bit time
    localparam logic [12:0] CLAMP_UP_NUM = 13'h0015;
    localparam logic [12:0] CLAMP_LO_NUM = 13'h0013;
    localparam logic [12:0] CLAMP_DEN = 13'h0014;
    localparam logic [12:0] CLAMP_LO_RND = 13'h000A;
    localparam logic [12:0] CLAMP_SAT = 13'h00FF;
    localparam logic [7:0] LIMIT_MAX = 8'hFF;

endpackage : wctc_pkg

// >>> wctc_filter_select.sv
// Edge filter time constant selection, fixed or adaptive.
// Assumes the caller holds the last measured falling edge spacing.
`timescale 1ns/100ps
`default_nettype none
module wctc_filter_select
    import wctc_pkg::*;
(
    input wire logic [1:0] filterMode,
    input wire logic [3:0] edgeSpacing,
    output logic [5:0] timeConstant
);

    ////////////////////////////////////////////////////////////////////////
    // Mode decode, adaptive bands by spacing
    always_comb begin
        case (filterMode)
            WCTC_FILT_TC8: begin
                timeConstant = TC_8;
            end
            WCTC_FILT_TC16: begin
                timeConstant = TC_16;
            end
            WCTC_FILT_TC32: begin
                timeConstant = TC_32;
            end
            WCTC_FILT_ADAPT: begin
                // Short spacing, long constant
                if (edgeSpacing >= SP32_MIN && edgeSpacing <= SP32_MAX) begin
                    timeConstant = TC_32;
                end else if (edgeSpacing >= SP16_MIN && edgeSpacing <= SP16_MAX) begin
                    timeConstant = TC_16;
                end else if (edgeSpacing >= SP8_MIN && edgeSpacing <= SP8_MAX) begin
                    timeConstant = TC_8;
                end else begin
                    // Out of band spacing falls back to the middle value
                    timeConstant = TC_16;
                end
            end
            default: begin
                timeConstant = TC_16;
            end
        endcase
    end

endmodule : wctc_filter_select
`default_nettype wire

// >>> wctc_limit_clamp.sv
// Clamp of the bit time detection limits to five percent of the bit time.
// Assumes the bit time low byte comes from the bit timing register.
`timescale 1ns/100ps
`default_nettype none
module wctc_limit_clamp
    import wctc_pkg::*;
(
    input wire logic [7:0] bitTime,
    input wire logic [7:0] upperLimit,
    input wire logic [7:0] lowerLimit,
    output logic [7:0] upperBound,
    output logic [7:0] lowerBound,
    output logic [7:0] upperEff,
    output logic [7:0] lowerEff
);

    logic [12:0] upProd; // Bit time times 21
    logic [12:0] upQuot; // Upper bound, rounded down
    logic [12:0] loProd; // Bit time times 19, plus rounding
    logic [12:0] loQuot; // Lower bound, rounded to nearest

    ////////////////////////////////////////////////////////////////////////
    // Bounds and clamped limits
    always_comb begin
        upProd = {5'h00, bitTime} * CLAMP_UP_NUM;
        upQuot = upProd / CLAMP_DEN;
        loProd = ({5'h00, bitTime} * CLAMP_LO_NUM) + CLAMP_LO_RND;
        loQuot = loProd / CLAMP_DEN;
        // Saturate so a large bit time cannot wrap the bound
        upperBound = (upQuot > CLAMP_SAT) ? LIMIT_MAX : upQuot[7:0];
        lowerBound = loQuot[7:0];
        upperEff = (upperLimit > upperBound) ? upperBound : upperLimit;
        lowerEff = (lowerLimit < lowerBound) ? lowerBound : lowerLimit;
    end

endmodule : wctc_limit_clamp
`default_nettype wire

// >>> wctc_wake_cdr_trim_config.sv
// Selective wake trim, calibration and clock data recovery configuration bank.
// Assumes the serial interface decodes frames into word reads and writes,
// and that the trim unlock field is supplied by another register.
//
// Contract
// - Receiver select bit 14, unlock-protected
// - Temperature coefficient trim writable only when unlocked
// - Coarse oscillator trim writable only when unlocked
// - Reserved bits always read zero
// - Calibration value read-only, high and low byte
// - Clock select picks 75 down to 9.375 MHz
// - Filter field picks 8, 16, 32, adaptive
// - Adaptive constant follows falling edge spacing captured while recovery is enabled
// - Bit zero enables clock data recovery
// - Reset loads register defaults; restart keeps fields
// - Limits hold upper, lower; clamped five percent
`timescale 1ns/100ps
`default_nettype none
module wctc_wake_cdr_trim_config
    import wctc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [6:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    input wire logic [1:0] trimUnlock,
    input wire logic [15:0] calValue,
    input wire logic calValid,
    input wire logic [7:0] bitTimeLow,
    input wire logic [3:0] edgeSpacing,
    input wire logic edgeSpacingValid,
    output logic wakeReceiverSelect,
    output logic [4:0] tempCoefTrim,
    output logic [6:0] oscCoarseTrim,
    output logic recoveryEnable,
    output logic [1:0] recoveryClockSelect,
    output logic [16:0] recoveryClockKhz,
    output logic [5:0] filterConstant,
    output logic [7:0] upperLimitEff,
    output logic [7:0] lowerLimitEff
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [15:0] trimReg_ff; // Trim and options word
    logic [15:0] nxt_trimReg;
    logic [15:0] calReg_ff; // Calibration result word
    logic [15:0] nxt_calReg;
    logic [15:0] ctrlReg_ff; // Recovery control word
    logic [15:0] nxt_ctrlReg;
    logic [15:0] limitReg_ff; // Bit time limit word
    logic [15:0] nxt_limitReg;
    logic [15:0] rdData_ff; // Read answer
    logic [15:0] nxt_rdData;
    logic [3:0] spacing_ff; // Last measured falling edge spacing
    logic [3:0] nxt_spacing;

    // Decoded accesses
    logic unlocked; // Protected fields open
    logic wrTrim; // Write to trim word
    logic wrCtrl; // Write to control word
    logic wrLimit; // Write to limit word

    // Registered outputs
    logic rxSel_ff;
    logic nxt_rxSel;
    logic [4:0] tcoef_ff;
    logic [4:0] nxt_tcoef;
    logic [6:0] coarse_ff;
    logic [6:0] nxt_coarse;
    logic recEn_ff;
    logic nxt_recEn;
    logic [1:0] clkSel_ff;
    logic [1:0] nxt_clkSel;
    logic [16:0] clkKhz_ff;
    logic [16:0] nxt_clkKhz;
    logic [5:0] filtTc_ff;
    logic [5:0] nxt_filtTc;
    logic [7:0] upEff_ff;
    logic [7:0] nxt_upEff;
    logic [7:0] loEff_ff;
    logic [7:0] nxt_loEff;

    // Helper results
    logic [5:0] tcSel; // Selected filter constant
    logic [7:0] upBound; // Upper clamp bound
    logic [7:0] loBound; // Lower clamp bound
    logic [7:0] upClamped; // Clamped upper limit
    logic [7:0] loClamped; // Clamped lower limit

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    always_comb begin
        unlocked = (trimUnlock == TRIM_UNLOCK_KEY);
        wrTrim = regWrEn && (regAddr == OFS_TRIM_OPTIONS);
        wrCtrl = regWrEn && (regAddr == OFS_RECOVERY_CTRL);
        wrLimit = regWrEn && (regAddr == OFS_BIT_TIME_LIMITS);
    end

    ////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        nxt_trimReg = trimReg_ff;
        nxt_calReg = calReg_ff;
        nxt_ctrlReg = ctrlReg_ff;
        nxt_limitReg = limitReg_ff;
        nxt_spacing = spacing_ff;
        // Protected word only opens with the unlock key
        if (wrTrim && unlocked) begin
            nxt_trimReg = regWrData & TRIM_IMPL_MASK;
        end
        // Locked writes leave the word untouched, without an error
        if (wrTrim && !unlocked) begin
            nxt_trimReg = trimReg_ff;
        end
        // Calibration word follows the calibration logic only
        if (calValid) begin
            nxt_calReg = calValue;
        end
        // Control word, reserved bits dropped
        if (wrCtrl) begin
            nxt_ctrlReg = regWrData & CTRL_IMPL_MASK;
        end
        // Limit word, fully writable
        if (wrLimit) begin
            nxt_limitReg = regWrData;
        end
        // Edge spacing is tracked only while recovery runs
        if (edgeSpacingValid && ctrlReg_ff[RECEN_BIT]) begin
            nxt_spacing = edgeSpacing;
        end
    end

    // Register storage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            // Power-on and soft reset; restart keeps the stored fields
            trimReg_ff <= TRIM_RST;
            calReg_ff <= CAL_RST;
            ctrlReg_ff <= CTRL_RST;
            limitReg_ff <= LIMIT_RST;
            spacing_ff <= SPACING_RST;
        end else begin
            trimReg_ff <= nxt_trimReg;
            calReg_ff <= nxt_calReg;
            ctrlReg_ff <= nxt_ctrlReg;
            limitReg_ff <= nxt_limitReg;
            spacing_ff <= nxt_spacing;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answer, one cycle after the read strobe
    always_comb begin
        nxt_rdData = rdData_ff;
        if (regRdEn) begin
            case (regAddr)
                OFS_TRIM_OPTIONS: begin
                    nxt_rdData = trimReg_ff & TRIM_IMPL_MASK;
                end
                OFS_CAL_STATUS: begin
                    nxt_rdData = calReg_ff;
                end
                OFS_RECOVERY_CTRL: begin
                    nxt_rdData = ctrlReg_ff & CTRL_IMPL_MASK;
                end
                OFS_BIT_TIME_LIMITS: begin
                    nxt_rdData = limitReg_ff;
                end
                default: begin
                    // Unmapped words read zero
                    nxt_rdData = WORD_ZERO;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_ff <= WORD_ZERO;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Filter constant and limit clamp helpers
    wctc_filter_select u_filter (
        .filterMode(ctrlReg_ff[FILT_HI:FILT_LO]),
        .edgeSpacing(spacing_ff),
        .timeConstant(tcSel)
    );

    wctc_limit_clamp u_clamp (
        .bitTime(bitTimeLow),
        .upperLimit(limitReg_ff[LIM_UP_HI:LIM_UP_LO]),
        .lowerLimit(limitReg_ff[LIM_LO_HI:LIM_LO_LO]),
        .upperBound(upBound),
        .lowerBound(loBound),
        .upperEff(upClamped),
        .lowerEff(loClamped)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output next values
    always_comb begin
        nxt_rxSel = trimReg_ff[RXSEL_BIT];
        nxt_tcoef = trimReg_ff[TCOEF_HI:TCOEF_LO];
        nxt_coarse = trimReg_ff[COARSE_HI:COARSE_LO];
        nxt_recEn = ctrlReg_ff[RECEN_BIT];
        nxt_clkSel = ctrlReg_ff[CLKSEL_HI:CLKSEL_LO];
        // Each select step halves the recovery clock
        nxt_clkKhz = RCLK_BASE_KHZ >> ctrlReg_ff[CLKSEL_HI:CLKSEL_LO];
        nxt_filtTc = tcSel;
        nxt_upEff = upClamped;
        nxt_loEff = loClamped;
    end

    // Output registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxSel_ff <= TRIM_RST[RXSEL_BIT];
            tcoef_ff <= TRIM_RST[TCOEF_HI:TCOEF_LO];
            coarse_ff <= TRIM_RST[COARSE_HI:COARSE_LO];
            recEn_ff <= CTRL_RST[RECEN_BIT];
            clkSel_ff <= CTRL_RST[CLKSEL_HI:CLKSEL_LO];
            clkKhz_ff <= RCLK_BASE_KHZ;
            filtTc_ff <= TC_16;
            upEff_ff <= LIMIT_RST[LIM_UP_HI:LIM_UP_LO];
            loEff_ff <= LIMIT_RST[LIM_LO_HI:LIM_LO_LO];
        end else begin
            rxSel_ff <= nxt_rxSel;
            tcoef_ff <= nxt_tcoef;
            coarse_ff <= nxt_coarse;
            recEn_ff <= nxt_recEn;
            clkSel_ff <= nxt_clkSel;
            clkKhz_ff <= nxt_clkKhz;
            filtTc_ff <= nxt_filtTc;
            upEff_ff <= nxt_upEff;
            loEff_ff <= nxt_loEff;
        end
    end

    // Port drive
    assign regRdData = rdData_ff;
    assign wakeReceiverSelect = rxSel_ff;
    assign tempCoefTrim = tcoef_ff;
    assign oscCoarseTrim = coarse_ff;
    assign recoveryEnable = recEn_ff;
    assign recoveryClockSelect = clkSel_ff;
    assign recoveryClockKhz = clkKhz_ff;
    assign filterConstant = filtTc_ff;
    assign upperLimitEff = upEff_ff;
    assign lowerLimitEff = loEff_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Locked write to the protected word
    sequence s_locked_trim_wr;
        regWrEn && (regAddr == OFS_TRIM_OPTIONS) && (trimUnlock != TRIM_UNLOCK_KEY);
    endsequence

    // Unlocked write to the protected word
    sequence s_open_trim_wr;
        regWrEn && (regAddr == OFS_TRIM_OPTIONS) && (trimUnlock == TRIM_UNLOCK_KEY);
    endsequence

    // Adaptive mode with a captured spacing in a band
    sequence s_adapt_short;
        edgeSpacingValid && ctrlReg_ff[RECEN_BIT] && !wrCtrl &&
            (ctrlReg_ff[FILT_HI:FILT_LO] == WCTC_FILT_ADAPT) &&
            (edgeSpacing >= SP32_MIN) && (edgeSpacing <= SP32_MAX)
            ##1 (ctrlReg_ff[FILT_HI:FILT_LO] == WCTC_FILT_ADAPT);
    endsequence

    sequence s_adapt_long;
        edgeSpacingValid && ctrlReg_ff[RECEN_BIT] && !wrCtrl &&
            (ctrlReg_ff[FILT_HI:FILT_LO] == WCTC_FILT_ADAPT) &&
            (edgeSpacing >= SP8_MIN) && (edgeSpacing <= SP8_MAX)
            ##1 (ctrlReg_ff[FILT_HI:FILT_LO] == WCTC_FILT_ADAPT);
    endsequence

    a_trim_locked_hold: assert property (s_locked_trim_wr |=> ##1 $stable(oscCoarseTrim) && $stable(tempCoefTrim)) else $error("locked write changed trim");
    a_rxsel_locked: assert property (s_locked_trim_wr |=> ##1 $stable(wakeReceiverSelect)) else $error("locked write changed receiver select");
    a_trim_open_write: assert property (s_open_trim_wr |-> ##2 (tempCoefTrim == $past(regWrData[TCOEF_HI:TCOEF_LO], 2)) && (oscCoarseTrim == $past(regWrData[COARSE_HI:COARSE_LO], 2)) && (wakeReceiverSelect == $past(regWrData[RXSEL_BIT], 2))) else $error("unlocked trim write lost");
    a_reserved_zero: assert property ((regRdEn && (regAddr == OFS_TRIM_OPTIONS)) |=> ((regRdData & ~TRIM_IMPL_MASK) == WORD_ZERO)) else $error("reserved trim bits read nonzero");
    a_cal_readback: assert property ((calValid ##1 (regRdEn && !calValid && (regAddr == OFS_CAL_STATUS))) |=> (regRdData == $past(calValue, 2))) else $error("calibration readback wrong");
    a_clock_rate: assert property (wrCtrl |-> ##2 (recoveryClockKhz == (RCLK_BASE_KHZ >> $past(regWrData[CLKSEL_HI:CLKSEL_LO], 2)))) else $error("recovery clock rate wrong");
    a_filter_fixed: assert property ((wrCtrl && (regWrData[FILT_HI:FILT_LO] == WCTC_FILT_TC16)) |-> ##2 (filterConstant == TC_16)) else $error("fixed filter constant wrong");
    a_adapt_short: assert property (s_adapt_short |=> (filterConstant == TC_32)) else $error("adaptive short spacing constant wrong");
    a_adapt_long: assert property (s_adapt_long |=> (filterConstant == TC_8)) else $error("adaptive long spacing constant wrong");
    a_enable_out: assert property (wrCtrl |-> ##2 (recoveryEnable == $past(regWrData[RECEN_BIT], 2))) else $error("recovery enable not applied");
    a_reset_values: assert property (@(posedge mclk) disable iff (1'b0) sys_rst |=> (trimReg_ff == TRIM_RST) && (ctrlReg_ff == CTRL_RST) && (limitReg_ff == LIMIT_RST)) else $error("reset value wrong");
    a_limit_clamp: assert property ($stable(bitTimeLow) && !wrLimit |=> (upperLimitEff <= $past(upBound)) && (lowerLimitEff >= $past(loBound))) else $error("limit not clamped");

endmodule : wctc_wake_cdr_trim_config
`default_nettype wire

// >>> wctc_sw_model.sv
// Software side model that drives the register port of the bank.
// Assumes the bank takes strobes on the rising edge of mclk.
`timescale 1ns/100ps
`default_nettype none
module wctc_sw_model
    import wctc_pkg::*;
(
    input wire logic mclk,
    output logic [6:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData
);
    ////////////////////////////////////////////////////////////////////////
    // Port idle at time zero
    initial begin
        regAddr = 7'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 16'h0000;
    end
    // Word write; released lines show the inverse, not a stale value
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask : wr
    // Word read; answer taken a cycle after the strobe
    task automatic rd(input logic [6:0] a, output logic [15:0] q);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        regAddr = ~a;
        q = regRdData;
    endtask : rd
endmodule : wctc_sw_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the trim and recovery configuration bank.
// Assumes the software model owns the register port.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import wctc_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic mclk = 1'b0;
    logic sys_rst, regWrEn, regRdEn, calValid, edgeSpacingValid;
    logic wakeReceiverSelect, recoveryEnable;
    logic [6:0] regAddr, oscCoarseTrim;
    logic [15:0] regWrData, regRdData, calValue, rdq, wd;
    logic [1:0] trimUnlock, recoveryClockSelect;
    logic [7:0] bitTimeLow, upperLimitEff, lowerLimitEff;
    logic [3:0] edgeSpacing;
    logic [4:0] tempCoefTrim;
    logic [16:0] recoveryClockKhz;
    logic [5:0] filterConstant;
    // Spacing bands and their time constants
    logic [3:0] spc [7] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'h1};
    logic [5:0] tcx [7] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h08, 6'h08, 6'h10};
    // Bit times and limit words for the clamp
    logic [7:0] bts [4] = '{8'h96, 8'h96, 8'h96, 8'h4B};
    logic [15:0] lims [4] = '{16'hFFFF, 16'h0000, 16'h9D8F, 16'h4E47};
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    initial forever #50 mclk = ~mclk;
    wctc_sw_model sw (.mclk, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData);
    wctc_wake_cdr_trim_config dut (.mclk, .sys_rst, .regAddr, .regWrEn, .regRdEn,
        .regWrData, .regRdData, .trimUnlock, .calValue, .calValid, .bitTimeLow,
        .edgeSpacing, .edgeSpacingValid, .wakeReceiverSelect, .tempCoefTrim,
        .oscCoarseTrim, .recoveryEnable, .recoveryClockSelect, .recoveryClockKhz,
        .filterConstant, .upperLimitEff, .lowerLimitEff);
    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict and helpers
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        sw.rd(a, rdq);
        chk({1'b0, rdq}, {1'b0, exp});
    endtask : rdchk
    task automatic rst_pulse();
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
    endtask : rst_pulse
    task automatic reset_vals();
        rdchk(OFS_TRIM_OPTIONS, 16'h0000);
        rdchk(OFS_CAL_STATUS, 16'h0000);
        rdchk(OFS_RECOVERY_CTRL, 16'h0004);
        rdchk(OFS_BIT_TIME_LIMITS, 16'h9D8F);
        chk(17'(filterConstant), 17'h00010);
    endtask : reset_vals
    // One captured spacing, constant seen two edges on
    task automatic spc_pulse(input logic [3:0] s);
        edgeSpacing = s;
        edgeSpacingValid = 1'b1;
        @(negedge mclk);
        edgeSpacingValid = 1'b0;
        @(negedge mclk);
    endtask : spc_pulse
    // Expected clamp: upper at most plus five, lower at least minus five percent
    function automatic logic [7:0] upExp(input logic [7:0] bt, input logic [7:0] u);
        logic [12:0] b;
        b = (13'(bt) * 13'h0015) / 13'h0014;
        b = (b > 13'h00FF) ? 13'h00FF : b;
        return (13'(u) < b) ? u : b[7:0];
    endfunction : upExp
    function automatic logic [7:0] loExp(input logic [7:0] bt, input logic [7:0] l);
        logic [12:0] b;
        b = (13'(bt) * 13'h0013 + 13'h000A) / 13'h0014;
        return (13'(l) > b) ? l : b[7:0];
    endfunction : loExp
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        trimUnlock = 2'h0;
        calValue = 16'h0000;
        calValid = 1'b0;
        bitTimeLow = 8'h96;
        edgeSpacing = 4'h0;
        edgeSpacingValid = 1'b0;
        rst_pulse();
        reset_vals();
        chk(recoveryClockKhz, 17'h124F8);
        // Trim word written locked, then with the key, then locked again
        trimUnlock = 2'h1;
        sw.wr(OFS_TRIM_OPTIONS, 16'hFFFF);
        rdchk(OFS_TRIM_OPTIONS, 16'h0000);
        trimUnlock = 2'h3;
        sw.wr(OFS_TRIM_OPTIONS, 16'hFFFF);
        rdchk(OFS_TRIM_OPTIONS, 16'h4FFF);
        chk({4'h0, wakeReceiverSelect, tempCoefTrim, oscCoarseTrim}, 17'h01FFF);
        trimUnlock = 2'h2;
        sw.wr(OFS_TRIM_OPTIONS, 16'h0000);
        rdchk(OFS_TRIM_OPTIONS, 16'h4FFF);
        // Calibration capture; writes to it are dropped
        calValue = 16'hA55A;
        calValid = 1'b1;
        // Read strobe in the cycle right after the capture
        fork
            sw.rd(OFS_CAL_STATUS, rdq);
            begin
                @(negedge mclk);
                calValid = 1'b0;
                calValue = 16'h5AA5;
            end
        join
        chk({1'b0, rdq}, 17'h0A55A);
        sw.wr(OFS_CAL_STATUS, 16'h1234);
        rdchk(OFS_CAL_STATUS, 16'hA55A);
        // Every clock select and fixed filter, reserved bits set
        for (int c = 0; c < 4; c++) begin
            for (int f = 0; f < 3; f++) begin
                wd = 16'hFF92 | 16'(c << 5) | 16'(f << 2) | 16'((c + f) & 1);
                sw.wr(OFS_RECOVERY_CTRL, wd);
                rdchk(OFS_RECOVERY_CTRL, wd & 16'h006D);
                chk(recoveryClockKhz, 17'h124F8 >> c);
                chk(17'(recoveryClockSelect), 17'(c));
                chk(17'(filterConstant), 17'h00008 << f);
                chk(17'(recoveryEnable), 17'((c + f) & 1));
            end
        end
        // Adaptive constant per spacing band, then capture off
        sw.wr(OFS_RECOVERY_CTRL, 16'h000D);
        for (int i = 0; i < 7; i++) begin
            spc_pulse(spc[i]);
            chk(17'(filterConstant), 17'(tcx[i]));
        end
        sw.wr(OFS_RECOVERY_CTRL, 16'h000C);
        spc_pulse(4'h2);
        chk(17'(filterConstant), 17'h00010);
        chk(17'(recoveryEnable), 17'h00000);
        // Limit words and clamp; last pair at the shorter bit time
        for (int i = 0; i < 4; i++) begin
            bitTimeLow = bts[i];
            sw.wr(OFS_BIT_TIME_LIMITS, lims[i]);
            rdchk(OFS_BIT_TIME_LIMITS, lims[i]);
            chk(17'(upperLimitEff), 17'(upExp(bts[i], lims[i][15:8])));
            chk(17'(lowerLimitEff), 17'(loExp(bts[i], lims[i][7:0])));
        end
        // Unmapped place, then reset in mid run
        sw.wr(7'h10, 16'hFFFF);
        rdchk(7'h10, 16'h0000);
        rst_pulse();
        reset_vals();
        close_out();
    end
endmodule : testbench
`default_nettype wire
